// File: shi_pkg.sv
package shi_pkg;

  // widths of the serial frame
  localparam int SHI_ADDR_W = 13;
  localparam int SHI_DATA_W = 8;
  localparam int SHI_INSTR_W = 16;

  // instruction word field positions (after bit-order correction)
  localparam int SHI_RW_POS = 15;
  localparam int SHI_LEN_HI = 14;
  localparam int SHI_LEN_LO = 13;

  // transfer_length_code values
  localparam logic [1:0] SHI_LEN_ONE = 2'h0;
  localparam logic [1:0] SHI_LEN_TWO = 2'h1;
  localparam logic [1:0] SHI_LEN_THREE = 2'h2;
  localparam logic [1:0] SHI_LEN_STREAM = 2'h3;

  // bit counter landmarks
  localparam logic [3:0] SHI_INSTR_LAST = 4'hF;
  localparam logic [2:0] SHI_BYTE_LAST = 3'h7;
  localparam logic [2:0] SHI_BYTE_START = 3'h0;
  localparam logic [3:0] SHI_I2C_ACK_SLOT = 4'h8;
  localparam logic [3:0] SHI_I2C_WRAP = 4'h9;

  // fixed upper six bits of the i2c slave address
  localparam logic [5:0] SHI_I2C_ADDR_HI = 6'h36;

  // reset values
  localparam logic [SHI_ADDR_W-1:0] SHI_ADDR_RST = 13'h0000;
  localparam logic [SHI_DATA_W-1:0] SHI_DATA_RST = 8'h00;

  // i2c slave states
  typedef enum logic [2:0] {
    SHI_I2C_IDLE,
    SHI_I2C_ADDR,
    SHI_I2C_WR,
    SHI_I2C_RD,
    SHI_I2C_IGN
  } shi_i2c_e;

endpackage

// File: shi_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a vector of independent levels
module shi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] metaQ;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      metaQ <= '0;
      q <= '0;
    end else begin
      metaQ <= d;
      q <= metaQ;
    end
  end

endmodule

// File: shi_serial_host_interface.sv
`timescale 1ns/1ps
// Contract
// - code 00 moves one byte, stall allowed
// - codes 01/10 move two/three bytes, stall allowed
// - code 11 streams; early select rise ends cycle
// - data units after instruction are 8-bit words
// - msb first default, lsb first when configured
// - lsb first fully reverses bit sequence
// - separate output off: read data on sdio
// - separate output on: read data on sdo
// - i2c address 110110 plus address pin bit
// - start is sda fall while scl high
// - direction bit follows seven address bits
// - ack own address low in ninth clock
// - stop is sda rise while scl high
// - sda changes only while scl low
// - frame opens with 16-bit instruction, read flag
// - 13-bit start address, increments or decrements
// - select low picks spi, high picks i2c
// - select rise off byte boundary aborts spi
module shi_serial_host_interface (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csbPin,
  input wire logic sdioIn,
  input wire logic addrSelPin,
  input wire logic lsbFirst,
  input wire logic sdoActive,
  input wire logic [shi_pkg::SHI_DATA_W-1:0] regRdData,
  output logic [shi_pkg::SHI_ADDR_W-1:0] regRdAddr,
  output logic regWrStrobe,
  output logic [shi_pkg::SHI_ADDR_W-1:0] regWrAddr,
  output logic [shi_pkg::SHI_DATA_W-1:0] regWrData,
  output logic sdioOut,
  output logic sdioOe,
  output logic sdoOut,
  output logic sdoOe,
  output logic sdaOut,
  output logic sdaOe
);
  import shi_pkg::*;

  // ---------------- spi engine, sclk domain ----------------
  logic [1:0] cfgS;
  logic lsbS;
  logic sdoActS;
  logic spiRst;
  logic stallOk;
  logic [SHI_INSTR_W-2:0] instrShQ;
  logic [3:0] instrCntQ;
  logic dataPhQ;
  logic isReadQ;
  logic [1:0] lenQ;
  logic [SHI_ADDR_W-1:0] addrQ;
  logic [SHI_ADDR_W-1:0] nextAddr;
  logic [SHI_DATA_W-1:0] rxShQ;
  logic [SHI_DATA_W-1:0] rxByte;
  logic [2:0] byteBitQ;
  logic [1:0] byteCntQ;
  logic doneQ;
  logic rdTogQ;
  logic wrTogQ;
  logic [SHI_ADDR_W-1:0] wrAddrQ;
  logic [SHI_DATA_W-1:0] wrDataQ;
  logic [SHI_DATA_W-1:0] txShQ;
  logic [SHI_DATA_W-1:0] rdByteQ;
  logic [SHI_INSTR_W-1:0] instrWord;
  logic [SHI_INSTR_W-1:0] instrRaw;
  logic spiDrive;
  logic txBit;

  // configuration bits carried onto the serial clock
  shi_sync #(.W(2)) u_cfgSync (
    .clk(sclk),
    .rst(rst),
    .d({lsbFirst, sdoActive}),
    .q(cfgS)
  );
  assign lsbS = cfgS[1];
  assign sdoActS = cfgS[0];

  // stalling is tolerated only on a byte boundary: after the first instruction byte, or in the data of a finite transfer
  always_comb begin
    stallOk = 1'b0;
    if (!dataPhQ && instrCntQ[2:0] == 3'h0 && instrCntQ != 4'h0) begin
      stallOk = 1'b1;
    end else if (dataPhQ && byteBitQ == SHI_BYTE_START && lenQ != SHI_LEN_STREAM && !doneQ) begin
      stallOk = 1'b1;
    end
  end
  // select high clears the frame unless parked at a legal stall point
  assign spiRst = rst | (csbPin & ~stallOk);

  // instruction word with bit order undone
  assign instrRaw = {instrShQ, sdioIn};
  always_comb begin
    for (int i = 0; i < SHI_INSTR_W; i++) begin
      instrWord[i] = lsbS ? instrRaw[SHI_INSTR_W-1-i] : instrRaw[i];
    end
  end
  assign rxByte = lsbS ? {sdioIn, rxShQ[7:1]} : {rxShQ[6:0], sdioIn};
  assign nextAddr = lsbS ? addrQ + 13'h0001 : addrQ - 13'h0001;

  // instruction phase capture on rising sclk
  always_ff @(posedge sclk or posedge spiRst) begin
    if (spiRst) begin
      instrShQ <= '0;
      instrCntQ <= 4'h0;
      dataPhQ <= 1'b0;
      isReadQ <= 1'b0;
      lenQ <= SHI_LEN_ONE;
    end else if (!dataPhQ) begin
      instrShQ <= instrRaw[SHI_INSTR_W-2:0];
      instrCntQ <= instrCntQ + 4'h1;
      if (instrCntQ == SHI_INSTR_LAST) begin
        dataPhQ <= 1'b1;
        isReadQ <= instrWord[SHI_RW_POS];
        lenQ <= instrWord[SHI_LEN_HI:SHI_LEN_LO];
      end
    end
  end

  // data phase: byte assembly, counting and address stepping
  always_ff @(posedge sclk or posedge spiRst) begin
    if (spiRst) begin
      rxShQ <= SHI_DATA_RST;
      byteBitQ <= SHI_BYTE_START;
      byteCntQ <= 2'h0;
      doneQ <= 1'b0;
      addrQ <= SHI_ADDR_RST;
    end else if (!dataPhQ) begin
      if (instrCntQ == SHI_INSTR_LAST) begin
        addrQ <= instrWord[SHI_ADDR_W-1:0];
      end
    end else if (!doneQ) begin
      rxShQ <= rxByte;
      byteBitQ <= byteBitQ + 3'h1;
      if (byteBitQ == SHI_BYTE_LAST) begin
        addrQ <= nextAddr;
        byteCntQ <= byteCntQ + 2'h1;
        if (lenQ != SHI_LEN_STREAM && byteCntQ == lenQ) begin
          doneQ <= 1'b1;
        end
      end
    end
  end

  // handshake words toward the system side; kept across frames
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rdTogQ <= 1'b0;
      wrTogQ <= 1'b0;
      wrAddrQ <= SHI_ADDR_RST;
      wrDataQ <= SHI_DATA_RST;
    end else if (!csbPin) begin
      if (!dataPhQ && instrCntQ == SHI_INSTR_LAST && instrWord[SHI_RW_POS]) begin
        rdTogQ <= ~rdTogQ; // first read address
      end else if (dataPhQ && !doneQ && byteBitQ == SHI_BYTE_LAST) begin
        if (isReadQ) begin
          rdTogQ <= ~rdTogQ; // prefetch next byte
        end else begin
          wrTogQ <= ~wrTogQ;
          wrAddrQ <= addrQ;
          wrDataQ <= rxByte;
        end
      end
    end
  end

  assign spiDrive = dataPhQ & isReadQ & ~doneQ;
  assign txBit = (byteBitQ == SHI_BYTE_START) ? (lsbS ? rdByteQ[0] : rdByteQ[7])
                                              : (lsbS ? txShQ[0] : txShQ[7]);

  // read data launched on falling sclk to the chosen pin
  always_ff @(negedge sclk or posedge spiRst) begin
    if (spiRst) begin
      txShQ <= SHI_DATA_RST;
      sdioOut <= 1'b0;
      sdioOe <= 1'b0;
      sdoOut <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      if (byteBitQ == SHI_BYTE_START) begin
        txShQ <= lsbS ? {1'b0, rdByteQ[7:1]} : {rdByteQ[6:0], 1'b0};
      end else begin
        txShQ <= lsbS ? {1'b0, txShQ[7:1]} : {txShQ[6:0], 1'b0};
      end
      sdioOut <= txBit;
      sdoOut <= txBit;
      sdioOe <= spiDrive & ~sdoActS;
      sdoOe <= spiDrive & sdoActS;
    end
  end

  // ---------------- system side ----------------
  logic [3:0] pinS;
  logic csbS;
  logic sclS;
  logic sdaS;
  logic addrSelS;
  logic [1:0] togS;
  logic [1:0] togPrevQ;
  logic rdEv;
  logic wrEv;
  logic [1:0] rdPendQ;

  // pins and handshake toggles into clk_sys
  shi_sync #(.W(4)) u_pinSync (
    .clk(clk_sys),
    .rst(rst),
    .d({csbPin, sclk, sdioIn, addrSelPin}),
    .q(pinS)
  );
  shi_sync #(.W(2)) u_togSync (
    .clk(clk_sys),
    .rst(rst),
    .d({rdTogQ, wrTogQ}),
    .q(togS)
  );
  assign csbS = pinS[3];
  assign sclS = pinS[2];
  assign sdaS = pinS[1];
  assign addrSelS = pinS[0];
  assign rdEv = togS[1] ^ togPrevQ[1];
  assign wrEv = togS[0] ^ togPrevQ[0];

  // i2c state
  shi_i2c_e stQ;
  logic [3:0] bitCntQ;
  logic [SHI_DATA_W-1:0] shQ;
  logic [SHI_DATA_W-1:0] txQ;
  logic rwQ;
  logic ptrSetQ;
  logic [SHI_ADDR_W-1:0] ptrQ;
  logic sclPrevQ;
  logic sdaPrevQ;
  logic i2cMode;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic sclFall;
  logic addrHit;
  logic i2cWrReq;

  assign i2cMode = csbS;
  assign startEv = i2cMode & sclS & sclPrevQ & sdaPrevQ & ~sdaS;
  assign stopEv = i2cMode & sclS & sclPrevQ & ~sdaPrevQ & sdaS;
  assign sclRise = i2cMode & sclS & ~sclPrevQ;
  assign sclFall = i2cMode & ~sclS & sclPrevQ;
  assign addrHit = (shQ[7:1] == {SHI_I2C_ADDR_HI, addrSelS});
  assign i2cWrReq = sclFall & (stQ == SHI_I2C_WR) & (bitCntQ == SHI_I2C_ACK_SLOT) & ptrSetQ;

  // edge history and toggle history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclPrevQ <= 1'b1;
      sdaPrevQ <= 1'b1;
      togPrevQ <= 2'h0;
    end else begin
      sclPrevQ <= sclS;
      sdaPrevQ <= sdaS;
      togPrevQ <= togS;
    end
  end

  // i2c slave: sample on scl rise, move sda on scl fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stQ <= SHI_I2C_IDLE;
      bitCntQ <= 4'h0;
      shQ <= SHI_DATA_RST;
      txQ <= SHI_DATA_RST;
      rwQ <= 1'b0;
      ptrSetQ <= 1'b0;
      ptrQ <= SHI_ADDR_RST;
      sdaOe <= 1'b0;
    end else if (!i2cMode || stopEv) begin
      stQ <= SHI_I2C_IDLE;
      sdaOe <= 1'b0;
    end else if (startEv) begin
      stQ <= SHI_I2C_ADDR;
      bitCntQ <= 4'h0;
      ptrSetQ <= 1'b0;
      sdaOe <= 1'b0;
    end else if (sclRise && stQ != SHI_I2C_IDLE && stQ != SHI_I2C_IGN) begin
      bitCntQ <= bitCntQ + 4'h1;
      if (bitCntQ < SHI_I2C_ACK_SLOT) begin
        shQ <= {shQ[6:0], sdaS};
      end else if (stQ == SHI_I2C_RD && sdaS) begin
        stQ <= SHI_I2C_IGN; // host nack ends the read
      end
    end else if (sclFall) begin
      case (stQ)
        SHI_I2C_ADDR: begin
          if (bitCntQ == SHI_I2C_ACK_SLOT) begin
            rwQ <= shQ[0];
            if (addrHit) begin
              sdaOe <= 1'b1;
            end else begin
              stQ <= SHI_I2C_IGN;
            end
          end else if (bitCntQ == SHI_I2C_WRAP) begin
            bitCntQ <= 4'h0;
            if (rwQ) begin
              stQ <= SHI_I2C_RD;
              txQ <= {regRdData[6:0], 1'b0};
              sdaOe <= ~regRdData[7];
            end else begin
              stQ <= SHI_I2C_WR;
              sdaOe <= 1'b0;
            end
          end
        end
        SHI_I2C_WR: begin
          if (bitCntQ == SHI_I2C_ACK_SLOT) begin
            sdaOe <= 1'b1;
            if (ptrSetQ) begin
              ptrQ <= ptrQ + 13'h0001;
            end else begin
              ptrQ <= {5'h00, shQ};
              ptrSetQ <= 1'b1;
            end
          end else if (bitCntQ == SHI_I2C_WRAP) begin
            bitCntQ <= 4'h0;
            sdaOe <= 1'b0;
          end
        end
        SHI_I2C_RD: begin
          if (bitCntQ == SHI_I2C_ACK_SLOT) begin
            sdaOe <= 1'b0;
            ptrQ <= ptrQ + 13'h0001;
          end else if (bitCntQ == SHI_I2C_WRAP) begin
            bitCntQ <= 4'h0;
            txQ <= {regRdData[6:0], 1'b0};
            sdaOe <= ~regRdData[7];
          end else begin
            txQ <= {txQ[6:0], 1'b0};
            sdaOe <= ~txQ[7];
          end
        end
        default: begin
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain pin only ever pulls low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // read address port shared by both links, spi byte captured after lookup
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdAddr <= SHI_ADDR_RST;
      rdPendQ <= 2'h0;
      rdByteQ <= SHI_DATA_RST;
    end else begin
      rdPendQ <= {rdPendQ[0], rdEv};
      if (rdEv) begin
        regRdAddr <= addrQ; // stable until the byte ends
      end else if (i2cMode) begin
        regRdAddr <= ptrQ;
      end
      if (rdPendQ[1]) begin
        rdByteQ <= regRdData;
      end
    end
  end

  // single write port fed by either link
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regWrStrobe <= 1'b0;
      regWrAddr <= SHI_ADDR_RST;
      regWrData <= SHI_DATA_RST;
    end else begin
      regWrStrobe <= wrEv | i2cWrReq;
      if (wrEv) begin
        regWrAddr <= wrAddrQ;
        regWrData <= wrDataQ;
      end else if (i2cWrReq) begin
        regWrAddr <= ptrQ;
        regWrData <= shQ;
      end
    end
  end

endmodule

// File: shi_serial_host_interface_checker.sv
`timescale 1ns/1ps
// watches pin drives and register strobes of the interface
module shi_serial_host_interface_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csbPin,
  input wire logic sdoActive,
  input wire logic regWrStrobe,
  input wire logic sdioOe,
  input wire logic sdoOe,
  input wire logic sdaOe
);
  // all checks on the system clock
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pin routing by wire mode, and no sda pull while select is low
  chk_sdo_quiet: assert property (!sdoActive |-> !sdoOe) else $error("sdo driven in 3-wire");
  chk_sdio_quiet: assert property (sdoActive |-> !sdioOe) else $error("sdio driven in 4-wire");
  chk_spi_no_ack: assert property (!csbPin |-> !sdaOe) else $error("sda pulled during spi");
  // open-drain pull moves only with clock low and lasts 30 to 50 cycles; write strobe lasts one cycle
  chk_sda_scl_low: assert property ($changed(sdaOe) |-> !sclk) else $error("sda moved, scl high");
  chk_ack_width: assert property ($rose(sdaOe) |-> ##[30:50] $fell(sdaOe)) else $error("ack width");
  chk_strobe_pulse: assert property (regWrStrobe |=> !regWrStrobe) else $error("strobe too long");
  // read data launched on falling clock
  chk_sdio_on_fall: assert property ($rose(sdioOe) |-> !sclk) else $error("sdio launch edge");
  chk_sdo_on_fall: assert property ($rose(sdoOe) |-> !sclk && sdoActive) else $error("sdo launch");
  // main scenarios reached
  cov_write: cover property (regWrStrobe);
  cov_ack: cover property ($rose(sdaOe));
  cov_sdo: cover property ($rose(sdoOe));
endmodule

bind shi_serial_host_interface shi_serial_host_interface_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csbPin(csbPin), .sdoActive(sdoActive),
  .regWrStrobe(regWrStrobe), .sdioOe(sdioOe), .sdoOe(sdoOe), .sdaOe(sdaOe)
);

// File: shi_host_model.sv
`timescale 1ns/1ps
// host master: spi or i2c on shared clock and data pins
module shi_host_model (
  output logic sclk,
  output logic csbPin,
  output logic hostDrv,
  input wire logic pin,
  input wire logic sdoLine
);
  // idle: select high, clock low, data released
  initial begin
    sclk = 1'b0;
    csbPin = 1'b1;
    hostDrv = 1'b1;
  end
  // select low opens an spi frame
  task automatic spiBegin();
    csbPin = 1'b0;
    #37;
  endtask
  // select rises with the clock idle
  task automatic spiEnd();
    #43;
    csbPin = 1'b1;
    #200;
  endtask
  // n bits, set mid-low, captured on rising
  task automatic spiByte(input logic [7:0] tx, input logic lsb, input logic useSdo, input int n,
                         output logic [7:0] rx);
    int b;
    for (int i = 0; i < n; i++) begin
      b = lsb ? i : 7 - i;
      hostDrv = tx[b];
      #40 sclk = 1'b1;
      rx[b] = useSdo ? sdoLine : pin;
      #80 sclk = 1'b0;
      #40;
    end
    hostDrv = 1'b1;
  endtask
  // start: data falls while clock high
  task automatic i2cStart();
    sclk = 1'b1;
    #80 hostDrv = 1'b0;
    #80 sclk = 1'b0;
    #40;
  endtask
  // msb first, data moves with clock low, then ack slot
  task automatic i2cByte(input logic [7:0] tx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hostDrv = tx[i];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      #40;
    end
    hostDrv = 1'b1;
    #40 sclk = 1'b1;
    ack = pin;
    #80 sclk = 1'b0;
    #40;
  endtask
  // read a byte msb first, then ack (0) or nack (1) in the ninth clock
  task automatic i2cRead(input logic nack, output logic [7:0] rx);
    hostDrv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #40 sclk = 1'b1;
      rx[i] = pin;
      #80 sclk = 1'b0;
      #40;
    end
    hostDrv = nack;
    #40 sclk = 1'b1;
    #80 sclk = 1'b0;
    #40;
    hostDrv = 1'b1;
  endtask
  // stop: data rises while clock high
  task automatic i2cStop();
    hostDrv = 1'b0;
    #40 sclk = 1'b1;
    #40 hostDrv = 1'b1;
    #80;
  endtask
endmodule

// File: test_shi_serial_host_interface.sv
`timescale 1ns/1ps
module test_shi_serial_host_interface;
  import shi_pkg::*;
  logic clk_sys, rst, addrSelPin, lsbFirst, sdoActive, ack;
  logic sclk, csbPin, hostDrv, pin, sdoLine, regWrStrobe, sdioOut, sdioOe, sdoOut, sdoOe, sdaOut, sdaOe;
  logic [SHI_DATA_W-1:0] regRdData, regWrData, rxA, rxB;
  logic [SHI_ADDR_W-1:0] regRdAddr, regWrAddr;
  logic [SHI_DATA_W-1:0] regMem [0:15];
  int n_fail, samples_checked, wrCnt, cycles;
  // shared data wire with pull-up, sdo floats to inverse
  assign pin = hostDrv & ~(sdioOe & ~sdioOut) & ~(sdaOe & ~sdaOut);
  assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
  assign regRdData = regMem[regRdAddr[3:0]];
  shi_serial_host_interface DUT (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csbPin(csbPin), .sdioIn(pin),
    .addrSelPin(addrSelPin), .lsbFirst(lsbFirst), .sdoActive(sdoActive), .regRdData(regRdData),
    .regRdAddr(regRdAddr), .regWrStrobe(regWrStrobe), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
  shi_host_model HOST (.sclk(sclk), .csbPin(csbPin), .hostDrv(hostDrv), .pin(pin), .sdoLine(sdoLine));
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // register file writes and run limit
  always @(posedge clk_sys) begin
    cycles++;
    if (regWrStrobe === 1'b1) begin
      regMem[regWrAddr[3:0]] <= regWrData;
      wrCnt++;
    end
    if (cycles == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // instruction word, fully reversed in lsb-first mode
  task automatic spiInstr(input logic [15:0] ins, input logic lsb);
    logic [7:0] rx;
    HOST.spiBegin();
    HOST.spiByte(lsb ? ins[7:0] : ins[15:8], lsb, 1'b0, 8, rx);
    HOST.spiByte(lsb ? ins[15:8] : ins[7:0], lsb, 1'b0, 8, rx);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // test sequence
  initial begin
    rst = 1'b1;
    addrSelPin = 1'b0;
    lsbFirst = 1'b0;
    sdoActive = 1'b0;
    for (int i = 0; i < 16; i++) regMem[i] = 8'hC0 + 8'(i);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    spiInstr({1'b0, SHI_LEN_ONE, 13'h0005}, 1'b0);
    HOST.spiByte(8'hA5, 1'b0, 1'b0, 8, rxA);
    HOST.spiEnd();
    cmp(16'(wrCnt), 16'h0001);
    cmp(16'(regWrAddr), 16'h0005);
    cmp(16'(regWrData), 16'h00A5);
    $display("test spi write one done");
    spiInstr({1'b0, SHI_LEN_THREE, 13'h0006}, 1'b0);
    HOST.spiEnd();
    HOST.spiBegin();
    for (int k = 0; k < 3; k++) HOST.spiByte(8'h30 + 8'(k), 1'b0, 1'b0, 8, rxA);
    HOST.spiEnd();
    cmp(16'(wrCnt), 16'h0004);
    cmp(16'(regMem[6]), 16'h0030);
    cmp(16'(regMem[4]), 16'h0032);
    $display("test spi write three done");
    @(posedge clk_sys);
    lsbFirst <= 1'b1;
    sdoActive <= 1'b1;
    spiInstr({1'b1, SHI_LEN_TWO, 13'h0002}, 1'b1);
    HOST.spiByte(8'hFF, 1'b1, 1'b1, 8, rxA);
    HOST.spiByte(8'hFF, 1'b1, 1'b1, 8, rxB);
    HOST.spiEnd();
    cmp(16'(rxA), 16'h00C2);
    cmp(16'(rxB), 16'h00C3);
    $display("test spi read lsb done");
    @(posedge clk_sys);
    lsbFirst <= 1'b0;
    sdoActive <= 1'b0;
    spiInstr({1'b1, SHI_LEN_ONE, 13'h0001}, 1'b0);
    HOST.spiByte(8'hFF, 1'b0, 1'b0, 8, rxA);
    HOST.spiEnd();
    cmp(16'(rxA), 16'h00C1);
    $display("test spi read sdio done");
    spiInstr({1'b0, SHI_LEN_STREAM, 13'h0008}, 1'b0);
    HOST.spiByte(8'h77, 1'b0, 1'b0, 8, rxA);
    HOST.spiByte(8'h66, 1'b0, 1'b0, 4, rxA);
    HOST.spiEnd();
    cmp(16'(regMem[8]), 16'h0077);
    cmp(16'(regMem[7]), 16'h00C7);
    cmp(16'(wrCnt), 16'h0005);
    $display("test spi abort done");
    @(posedge clk_sys);
    addrSelPin <= 1'b1;
    HOST.i2cStart();
    HOST.i2cByte(8'hDA, ack);
    cmp(16'(ack), 16'h0000);
    HOST.i2cByte(8'h09, ack);
    cmp(16'(ack), 16'h0000);
    HOST.i2cByte(8'hB5, ack);
    HOST.i2cStop();
    cmp(16'(regMem[9]), 16'h00B5);
    cmp(16'(wrCnt), 16'h0006);
    $display("test i2c write done");
    HOST.i2cStart();
    HOST.i2cByte(8'hD8, ack);
    cmp(16'(ack), 16'h0001);
    HOST.i2cByte(8'h0A, ack);
    cmp(16'(ack), 16'h0001);
    HOST.i2cStop();
    cmp(16'(wrCnt), 16'h0006);
    $display("test i2c foreign done");
    HOST.i2cStart();
    HOST.i2cByte(8'hDA, ack);
    cmp(16'(ack), 16'h0000);
    HOST.i2cByte(8'h09, ack);
    HOST.i2cStart();
    HOST.i2cByte(8'hDB, ack);
    cmp(16'(ack), 16'h0000);
    HOST.i2cRead(1'b1, rxA);
    HOST.i2cStop();
    cmp(16'(rxA), 16'h00B5);
    cmp(16'(wrCnt), 16'h0006);
    cmp(16'(sdaOut), 16'h0000);
    $display("test i2c read done");
    tally_and_finish();
  end
endmodule
